/* File: common/adcs_consts.svh */
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH

// Pin slots in the synchroniser vector
`define ADCS_PIN_SCLK 0
`define ADCS_PIN_CSN 1
`define ADCS_PIN_FS 2
`define ADCS_PIN_SDI 3
`define ADCS_PIN_STROBE 4

// Serial frame layout
`define ADCS_FRAME_BITS 5'h10
`define ADCS_CMD_BITS 5'h04

// Command codes
`define ADCS_CMD_POWER_DOWN 4'h8
`define ADCS_CMD_READ_SETUP 4'h9
`define ADCS_CMD_WRITE_SETUP 4'hA
`define ADCS_CMD_TEST_FIRST 4'hB
`define ADCS_CMD_TEST_LAST 4'hD
`define ADCS_CMD_FIFO_READ 4'hE

// Setup word field positions
`define ADCS_F_REF_INT 11
`define ADCS_F_TWOS 10
`define ADCS_F_LONG_SAMPLE 9
`define ADCS_F_CLK_DIV2 8
`define ADCS_F_PSEUDO_DIFF 7
`define ADCS_F_MODE_HI 6
`define ADCS_F_MODE_LO 5
`define ADCS_F_SEQ_HI 4
`define ADCS_F_SEQ_LO 3
`define ADCS_F_EOC_SEL 2
`define ADCS_F_THR_HI 1
`define ADCS_F_THR_LO 0

// Reset value of the setup word
`define ADCS_SETUP_RESET 12'h000

// Sampling lengths in serial clocks
`define ADCS_SAMPLE_SHORT 5'h0C
`define ADCS_SAMPLE_LONG 5'h18

// Result buffer depth
`define ADCS_FIFO_DEPTH 4'h8

`endif

/* File: common/adcs_pkg.sv */
`default_nettype none
package adcs_pkg;

    // Conversion modes held in the setup word
    typedef enum logic [1:0] {
        MODE_ONE_SHOT,
        MODE_REPEAT,
        MODE_SWEEP,
        MODE_REPEAT_SWEEP
    } adcs_mode_t;

    // Sample and convert sequencer
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SAMPLE,
        PH_CONVERT
    } adcs_phase_t;

endpackage
`default_nettype wire

/* File: rtl/adcs_pair_buffer.sv */
`default_nettype none
`include "adcs_consts.svh"

module adcs_pair_buffer #(
    parameter int WIDTH = 12
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic wrPtr;
        logic rdPtr;
        logic [1:0] count;
    } adcs_buf_state_t;

    adcs_buf_state_t r;
    adcs_buf_state_t n;

    // Handshakes come straight from the fill count
    assign inReady = (r.count != 2'h2);
    assign outValid = (r.count != 2'h0);
    assign outData = r.mem[r.rdPtr];

    // Push and pop, both allowed in one cycle
    always_comb begin
        n = r;
        if (inValid && inReady) begin
            n.mem[r.wrPtr] = inData;
            n.wrPtr = ~r.wrPtr;
        end
        if (outValid && outReady) begin
            n.rdPtr = ~r.rdPtr;
        end
        n.count = r.count + {1'b0, inValid && inReady} - {1'b0, outValid && outReady};
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/adcs_control.sv */
`default_nettype none
`include "adcs_consts.svh"

// Overview of operation
// - Single 12-bit setup word, kept through power-down
// - Setup write is 16 bits, pauses allowed
// - Setup read returns word after a single zero bit
// - Bit 11 picks internal or external reference
// - Bit 10 picks binary or two's complement
// - Bit 9 sets 12 or 24 clock sampling
// - Bit 8 divides conversion clock by two
// - Bit 7 selects pseudo-differential inputs
// - Bits 6..5 select the conversion mode
// - Bits 4..3 select the sweep channel order
// - Sweep order only used in sweep modes
// - Bit 2 makes event pin interrupt or busy
// - Bits 1..0 set the buffer threshold level
// - Sampling starts after a conversion command nibble
// - Strobe low samples, strobe rise converts
// - Stored result shifts out in next frame
// - Frame sync triggers with chip select held
// - One-shot bypasses buffer, signals busy or done
// - Threshold unread means buffer discarded, restart
// - Chip select framing: rise captures, fall shifts
// - Frame sync framing: fall captures, rise shifts
// - Buffer read returns result in upper twelve bits
module adcs_control (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic csN,
    input wire logic frameSync,
    input wire logic serialIn,
    input wire logic sampleWindowStrobeN,
    output logic serialOut,
    output logic serialOutEn,
    output logic eventPinN,
    output logic sampleHold,
    output logic convStart,
    output logic convTick,
    output logic [3:0] convChannel,
    output logic refInternal,
    output logic pseudoDiff,
    output logic powerDown,
    input wire logic [11:0] convResult,
    input wire logic convResultValid,
    output logic convResultReady
);

    typedef struct packed {
        logic [4:0] pinS1;
        logic [4:0] pinS2;
        logic [4:0] pinS3;
        logic [4:0] pinStable;
        logic frameActive;
        logic spiMode;
        logic [4:0] bitCnt;
        logic [11:0] shiftIn;
        logic [3:0] cmdReg;
        logic [15:0] outShift;
        logic [11:0] setupWord;
        logic powerDown;
        adcs_pkg::adcs_phase_t phase;
        logic extended;
        logic [4:0] sampleCnt;
        logic [3:0] selCode;
        logic convStart;
        logic convTick;
        logic divPhase;
        logic [2:0] sweepIdx;
        logic [7:0][11:0] fifoMem;
        logic [2:0] rdPtr;
        logic [2:0] wrPtr;
        logic [3:0] fifoCount;
        logic thrHit;
        logic [11:0] lastResult;
        logic intPending;
    } adcs_state_t;

    adcs_state_t r;
    adcs_state_t n;
    logic [11:0] bufData;
    logic bufValid;
    logic bufReady;
    adcs_pkg::adcs_mode_t mode;

    // Results from the core pass a two-entry buffer before storage
    adcs_pair_buffer #(
        .WIDTH(12)
    ) resultBuffer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inData(convResult),
        .inValid(convResultValid),
        .inReady(convResultReady),
        .outData(bufData),
        .outValid(bufValid),
        .outReady(bufReady)
    );

    assign mode = adcs_pkg::adcs_mode_t'(r.setupWord[`ADCS_F_MODE_HI:`ADCS_F_MODE_LO]);

    // Sweep order lookup; channel tables
    function automatic logic [2:0] sweepChannel(input logic [1:0] seq, input logic [2:0] idx);
        logic [2:0] ch;
        ch = idx;
        case (seq)
            2'h0: ch = idx;
            2'h1: ch = {idx[1:0], 1'b0};
            2'h2: ch = {idx[2:1], 1'b0};
            default: ch = {1'b0, idx[0], 1'b0};
        endcase
        return ch;
    endfunction

    // Draining stalls the core when the storage buffer is full
    // one-shot never waits on the buffer
    assign bufReady = (mode == adcs_pkg::MODE_ONE_SHOT) || (r.fifoCount != `ADCS_FIFO_DEPTH);

    // Pin and status outputs
    assign serialOut = r.outShift[15];
    assign serialOutEn = r.frameActive;
    assign sampleHold = (r.phase == adcs_pkg::PH_SAMPLE);
    assign convStart = r.convStart;
    assign convTick = r.convTick;
    assign powerDown = r.powerDown;
    assign refInternal = r.setupWord[`ADCS_F_REF_INT];
    assign pseudoDiff = r.setupWord[`ADCS_F_PSEUDO_DIFF];

    // sweep order steers channel only in sweep modes
    always_comb begin
        if (mode == adcs_pkg::MODE_SWEEP || mode == adcs_pkg::MODE_REPEAT_SWEEP) begin
            convChannel = {1'b0, sweepChannel(r.setupWord[`ADCS_F_SEQ_HI:`ADCS_F_SEQ_LO], r.sweepIdx)};
        end else begin
            convChannel = r.selCode;
        end
    end

    // event pin is busy only in one-shot with busy select
    always_comb begin
        if (mode == adcs_pkg::MODE_ONE_SHOT && r.setupWord[`ADCS_F_EOC_SEL]) begin
            eventPinN = ~(r.phase == adcs_pkg::PH_CONVERT);
        end else begin
            eventPinN = ~r.intPending;
        end
    end

    // Next-state logic for the whole control block
    always_comb begin
        logic [4:0] stableNow;
        logic [4:0] rise;
        logic [4:0] fall;
        logic capEdge;
        logic chgEdge;
        logic [3:0] cmdNow;
        logic [11:0] wordNow;
        logic [11:0] formatted;
        logic [4:0] sampleLen;
        logic [3:0] level;
        logic push;
        logic pop;
        logic clearFifo;
        stableNow = '0;
        rise = '0;
        fall = '0;
        capEdge = 1'b0;
        chgEdge = 1'b0;
        cmdNow = '0;
        wordNow = '0;
        formatted = '0;
        sampleLen = '0;
        level = '0;
        push = 1'b0;
        pop = 1'b0;
        clearFifo = 1'b0;
        n = r;
        n.convStart = 1'b0;
        n.convTick = 1'b0;

        // Three-stage sync; a level is taken once stages two and three agree
        n.pinS1 = {sampleWindowStrobeN, serialIn, frameSync, csN, sclk};
        n.pinS2 = r.pinS1;
        n.pinS3 = r.pinS2;
        stableNow = (~(r.pinS2 ^ r.pinS3) & r.pinS3) | ((r.pinS2 ^ r.pinS3) & r.pinStable);
        n.pinStable = stableNow;
        rise = stableNow & ~r.pinStable;
        fall = ~stableNow & r.pinStable;

        // chip-select framing captures on rise, shifts on fall
        // frame-sync framing captures on fall, shifts on rise
        capEdge = r.spiMode ? rise[`ADCS_PIN_SCLK] : fall[`ADCS_PIN_SCLK];
        chgEdge = r.spiMode ? fall[`ADCS_PIN_SCLK] : rise[`ADCS_PIN_SCLK];

        // Output shifter moves on the change edge
        if (r.frameActive && chgEdge) begin
            n.outShift = {r.outShift[14:0], 1'b0};
        end

        // result drain into one-shot holder or buffer
        // coding applied on the way in
        formatted = bufData ^ {r.setupWord[`ADCS_F_TWOS], 11'h000};
        if (bufValid && bufReady) begin
            if (mode == adcs_pkg::MODE_ONE_SHOT) begin
                n.lastResult = formatted;
            end else begin
                push = 1'b1;
                n.fifoMem[r.wrPtr] = formatted;
                n.wrPtr = r.wrPtr + 3'h1;
                n.sweepIdx = r.sweepIdx + 3'h1;
            end
        end

        // Capture serial input bits
        if (r.frameActive && capEdge && r.bitCnt != `ADCS_FRAME_BITS) begin
            n.shiftIn = {r.shiftIn[10:0], stableNow[`ADCS_PIN_SDI]};
            n.bitCnt = r.bitCnt + 5'h01;
            cmdNow = {r.shiftIn[2:0], stableNow[`ADCS_PIN_SDI]};
            wordNow = {r.shiftIn[10:0], stableNow[`ADCS_PIN_SDI]};
            if (n.bitCnt == `ADCS_CMD_BITS) begin
                n.cmdReg = cmdNow; // Kept for the whole frame
                // threshold not served by a read discards the buffer
                if (r.thrHit && cmdNow != `ADCS_CMD_FIFO_READ) begin
                    clearFifo = 1'b1;
                end
                // conversion commands open the sampling period
                if (!cmdNow[3] || (cmdNow >= `ADCS_CMD_TEST_FIRST && cmdNow <= `ADCS_CMD_TEST_LAST)) begin
                    n.phase = adcs_pkg::PH_SAMPLE;
                    n.extended = 1'b0;
                    n.sampleCnt = '0;
                    n.selCode = cmdNow;
                    n.powerDown = 1'b0;
                end else if (cmdNow == `ADCS_CMD_POWER_DOWN) begin
                    // power-down leaves the setup word untouched
                    n.powerDown = 1'b1;
                end else if (cmdNow == `ADCS_CMD_READ_SETUP) begin
                    // setup word follows a single zero bit
                    n.outShift = {1'b0, r.setupWord, 3'h0};
                end else if (cmdNow == `ADCS_CMD_FIFO_READ && r.fifoCount != 4'h0) begin
                    // word already loaded, consume the entry
                    pop = 1'b1;
                end
            end
            // the sixteenth captured bit completes a write
            if (n.bitCnt == `ADCS_FRAME_BITS && r.cmdReg == `ADCS_CMD_WRITE_SETUP) begin
                n.setupWord = wordNow;
                if (wordNow[`ADCS_F_MODE_HI:`ADCS_F_MODE_LO] != r.setupWord[`ADCS_F_MODE_HI:`ADCS_F_MODE_LO]) begin
                    clearFifo = 1'b1;
                end
            end
        end

        sampleLen = r.setupWord[`ADCS_F_LONG_SAMPLE] ? `ADCS_SAMPLE_LONG : `ADCS_SAMPLE_SHORT;
        case (r.phase)
            adcs_pkg::PH_IDLE: begin
                // strobe fall opens an extended sample
                if (fall[`ADCS_PIN_STROBE]) begin
                    n.phase = adcs_pkg::PH_SAMPLE;
                    n.extended = 1'b1;
                    n.powerDown = 1'b0;
                end
            end
            adcs_pkg::PH_SAMPLE: begin
                if (r.extended) begin
                    if (rise[`ADCS_PIN_STROBE]) begin
                        n.phase = adcs_pkg::PH_CONVERT;
                        n.convStart = 1'b1;
                        n.divPhase = 1'b0;
                    end
                end else if (capEdge) begin
                    n.sampleCnt = r.sampleCnt + 5'h01;
                    if (n.sampleCnt == sampleLen) begin
                        n.phase = adcs_pkg::PH_CONVERT;
                        n.convStart = 1'b1;
                        n.divPhase = 1'b0;
                    end
                end
            end
            default: begin
                // conversion clock is serial clock or half of it
                if (rise[`ADCS_PIN_SCLK]) begin
                    n.divPhase = ~r.divPhase;
                    n.convTick = ~r.setupWord[`ADCS_F_CLK_DIV2] | r.divPhase;
                end
                if (convResultValid && convResultReady) begin
                    n.phase = adcs_pkg::PH_IDLE;
                end
            end
        endcase

        // frame sync may restart frames with chip select held low
        if (rise[`ADCS_PIN_CSN]) begin
            n.frameActive = 1'b0;
        end else if ((fall[`ADCS_PIN_CSN] && stableNow[`ADCS_PIN_FS]) ||
                     (fall[`ADCS_PIN_FS] && !stableNow[`ADCS_PIN_CSN])) begin
            n.frameActive = 1'b1;
            n.spiMode = fall[`ADCS_PIN_CSN];
            n.bitCnt = '0;
            // stored result leads the new frame
            if (mode == adcs_pkg::MODE_ONE_SHOT) begin
                n.outShift = {r.lastResult, 4'h0};
                n.intPending = 1'b0;
            end else begin
                n.outShift = {r.fifoMem[r.rdPtr], 4'h0};
            end
        end

        // Buffer read side and fill count
        if (pop) begin
            n.rdPtr = r.rdPtr + 3'h1;
        end
        n.fifoCount = r.fifoCount + {3'h0, push} - {3'h0, pop};
        if (pop && n.fifoCount == 4'h0) begin
            n.thrHit = 1'b0;
            n.intPending = 1'b0;
        end
        // level index of newest entry is count minus one
        level = 4'h7 - {1'h0, r.setupWord[`ADCS_F_THR_HI:`ADCS_F_THR_LO], 1'b0} + 4'h1;
        if (push && n.fifoCount == level) begin
            n.thrHit = 1'b1;
            n.intPending = 1'b1;
        end
        // one-shot completion raises the done flag, set wins except over a buffer discard
        if (bufValid && bufReady && mode == adcs_pkg::MODE_ONE_SHOT) begin
            n.intPending = 1'b1;
        end
        if (clearFifo) begin
            n.rdPtr = '0;
            n.wrPtr = '0;
            n.fifoCount = '0;
            n.thrHit = 1'b0;
            n.intPending = 1'b0;
            n.sweepIdx = '0;
        end
    end

    // Single state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.pinS1 <= 5'h1F;
            r.pinS2 <= 5'h1F;
            r.pinS3 <= 5'h1F;
            r.pinStable <= 5'h1F;
            r.spiMode <= 1'b1;
            r.setupWord <= `ADCS_SETUP_RESET;
        end else begin
            r <= n;
        end
    end

endmodule
`default_nettype wire

/* File: test/adcs_core_model.sv */
`default_nettype none
module adcs_core_model #(
    parameter int DELAY = 40
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic convStart,
    input wire logic [3:0] convChannel,
    input wire logic convResultReady,
    output logic [11:0] convResult,
    output logic convResultValid
);
    timeunit 1ns;
    timeprecision 100ps;
    int waitCnt;
    logic [11:0] nextRes;
    logic [7:0] seqCnt;
    // Answers each start after a fixed delay, holds it until taken
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            convResultValid <= 1'b0;
            convResult <= 12'h000;
            nextRes <= 12'h000;
            waitCnt <= 0;
            seqCnt <= 8'h11;
        end else if (convStart) begin
            waitCnt <= DELAY;
            nextRes <= {convChannel, seqCnt};
        end else if (waitCnt == 1) begin
            waitCnt <= 0;
            convResultValid <= 1'b1;
            convResult <= nextRes;
        end else if (waitCnt > 1) begin
            waitCnt <= waitCnt - 1;
        end else if (convResultValid && convResultReady) begin
            convResultValid <= 1'b0;
            convResult <= ~convResult; // Released data no longer looks valid
            seqCnt <= seqCnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: test/adcs_control_assertions.sv */
`default_nettype none
module adcs_control_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic csN,
    input wire logic sampleWindowStrobeN,
    input wire logic serialOutEn,
    input wire logic sampleHold,
    input wire logic convStart,
    input wire logic convTick,
    input wire logic refInternal,
    input wire logic pseudoDiff
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] holdCnt;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Length of the current sampling phase, saturating
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) holdCnt <= 8'h00;
        else if (!sampleHold) holdCnt <= 8'h00;
        else if (holdCnt != 8'hFF) holdCnt <= holdCnt + 8'h01;
    end
    property p_conv_pulse;
        convStart |=> !convStart;
    endproperty
    a_conv_pulse: assert property (p_conv_pulse) else $error("convStart longer than one cycle");
    property p_conv_cause;
        convStart |-> (sampleHold || $past(sampleHold) || $past(sampleHold, 2));
    endproperty
    a_conv_cause: assert property (p_conv_cause) else $error("convStart without sampling");
    property p_hold_len;
        $fell(sampleHold) |-> $past(holdCnt) >= 8'h28;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("sampling phase too short");
    property p_en_rise;
        $rose(serialOutEn) |-> !csN;
    endproperty
    a_en_rise: assert property (p_en_rise) else $error("output enabled without chip select");
    property p_en_fall;
        $rose(csN) |-> ##[1:6] !serialOutEn;
    endproperty
    a_en_fall: assert property (p_en_fall) else $error("output still enabled after deselect");
    property p_setup_frame;
        ($changed(refInternal) || $changed(pseudoDiff)) |-> serialOutEn;
    endproperty
    a_setup_frame: assert property (p_setup_frame) else $error("setup changed outside a frame");
    property p_tick_pulse;
        convTick |=> !convTick;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("convTick longer than one cycle");
    property p_hold_cause;
        $rose(sampleHold) |-> (serialOutEn || !sampleWindowStrobeN);
    endproperty
    a_hold_cause: assert property (p_hold_cause) else $error("sampling began without a cause");
    cover property (convStart);
endmodule

bind adcs_control adcs_control_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .csN(csN),
    .sampleWindowStrobeN(sampleWindowStrobeN), .serialOutEn(serialOutEn), .sampleHold(sampleHold),
    .convStart(convStart), .convTick(convTick), .refInternal(refInternal), .pseudoDiff(pseudoDiff));
`default_nettype wire

/* File: test/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk = 1'b1;
    logic csN = 1'b1;
    logic frameSync = 1'b1;
    logic serialIn = 1'b0;
    logic strobeN = 1'b1;
    wire logic serialOut, serialOutEn, eventPinN, sampleHold, convStart, convTick;
    wire logic refInternal, pseudoDiff, powerDown, convResultValid, convResultReady;
    wire logic [3:0] convChannel;
    wire logic [11:0] convResult;
    logic q [0:16];
    logic [15:0] shown;
    logic [11:0] setupSeen;
    logic [3:0] chAtStart = 4'h0;
    int takenCnt = 0;
    int startCnt = 0;
    int tickCnt = 0;
    int tickBase = 0;
    logic dsp = 1'b0;
    int bad_count = 0;
    int cmp_count = 0;
    int t;
    // System clock
    always #5 ref_clk = ~ref_clk;
    adcs_control u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .frameSync(frameSync),
        .serialIn(serialIn), .sampleWindowStrobeN(strobeN), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .eventPinN(eventPinN), .sampleHold(sampleHold), .convStart(convStart), .convTick(convTick),
        .convChannel(convChannel), .refInternal(refInternal), .pseudoDiff(pseudoDiff), .powerDown(powerDown),
        .convResult(convResult), .convResultValid(convResultValid), .convResultReady(convResultReady));
    adcs_core_model #(.DELAY(40)) u_core (.ref_clk(ref_clk), .rst_n(rst_n), .convStart(convStart),
        .convChannel(convChannel), .convResultReady(convResultReady), .convResult(convResult),
        .convResultValid(convResultValid));
    // Counts conversion starts and result handshakes
    always @(posedge ref_clk) begin
        if (convStart === 1'b1) begin
            startCnt <= startCnt + 1;
            chAtStart <= convChannel;
        end
        if (convResultValid === 1'b1 && convResultReady === 1'b1) takenCnt <= takenCnt + 1;
        if (convTick === 1'b1) tickCnt <= tickCnt + 1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Free serial clock pulses outside a frame
    task automatic clocks(input int n);
        repeat (n) begin
            sclk <= 1'b0;
            tick(5);
            sclk <= 1'b1;
            tick(5);
        end
    endtask
    // One frame opened by chip select, or by frame sync when dsp is set
    task automatic frame(input logic [15:0] w, input int pauseAt);
        if (dsp) frameSync <= 1'b0;
        else csN <= 1'b0;
        tick(8);
        q[0] = serialOut;
        for (int i = 0; i < 16; i++) begin
            if (i == pauseAt) tick(40);
            sclk <= 1'b0;
            serialIn <= w[15-i];
            tick(5);
            sclk <= 1'b1;
            tick(5);
            q[i+1] = serialOut;
        end
        tick(5);
        if (dsp) frameSync <= 1'b1;
        else csN <= 1'b1;
        tick(8);
        for (int k = 0; k < 16; k++) shown[15-k] = q[k];
        for (int k = 0; k < 12; k++) setupSeen[11-k] = q[5+k];
    endtask
    task automatic waitTaken(input int target);
        int n;
        n = 0;
        while (takenCnt < target && n < 3000) begin
            tick(1);
            n++;
        end
        if (n >= 3000) check("result handshake", 16'h0001, 16'h0000);
        tick(4);
    endtask
    task automatic conv(input logic [15:0] w);
        int n;
        n = takenCnt + 1;
        frame(w, 99);
        waitTaken(n);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        tick(40000);
        bad_count++;
        results();
    end
    // Main sequence
    initial begin
        tick(8);
        rst_n <= 1'b1;
        tick(3);
        check("reset outputs", 16'h0003, {11'h0, refInternal, pseudoDiff, serialOutEn, eventPinN, convResultReady});
        frame(16'h9000, 99);
        check("setup after reset", 16'h0000, {4'h0, setupSeen});
        frame(16'hA000, 99);
        frame(16'hAB83, 8);
        frame(16'h9000, 99);
        check("setup readback", 16'h0B83, {4'h0, setupSeen});
        check("reference and input", 16'h0003, {14'h0, refInternal, pseudoDiff});
        check("no start on setup frames", 16'h0000, 16'(startCnt));
        frame(16'hA004, 99);
        t = takenCnt + 1;
        frame(16'h3000, 99);
        check("channel at start", 16'h0103, {7'h0, 16'(startCnt) == 16'h0001, 4'h0, chAtStart});
        check("busy while converting", 16'h0000, {15'h0, eventPinN});
        waitTaken(t);
        check("busy after result", 16'h0001, {15'h0, eventPinN});
        frame(16'hE000, 99);
        check("one-shot result", 16'h0311, {4'h0, shown[15:4]});
        frame(16'hA400, 99);
        conv(16'h5000);
        check("done interrupt", 16'h0000, {15'h0, eventPinN});
        t = takenCnt + 1;
        frame(16'h0000, 99);
        check("two's complement result", 16'h0D12, {4'h0, shown[15:4]});
        check("interrupt cleared", 16'h0001, {15'h0, eventPinN});
        waitTaken(t);
        frame(16'hA000, 99);
        t = takenCnt + 1;
        strobeN <= 1'b0;
        tick(10);
        check("strobe sampling", 16'h0001, {15'h0, sampleHold});
        tick(80);
        strobeN <= 1'b1;
        tick(10);
        check("strobe start count", 16'h0004, 16'(startCnt));
        waitTaken(t);
        frame(16'hE000, 99);
        check("strobe result", 16'h0014, {8'h0, shown[11:4]});
        for (int m = 0; m < 2; m++) begin
            frame((m == 0) ? 16'hA048 : 16'hA068, 99);
            conv(16'h7000);
            check("first sweep channel", 16'h0000, {12'h0, chAtStart});
            conv(16'h7000);
            check("second sweep channel", 16'h0002, {12'h0, chAtStart});
        end
        for (int c = 0; c < 4; c++) begin
            frame(16'hA000, 99);
            frame(16'hA020 | 16'(c), 99);
            for (int k = 0; k < 7 - 2 * c; k++) conv(16'h2000);
            check("below threshold", 16'h0001, {15'h0, eventPinN});
            conv(16'h2000);
            check("threshold reached", 16'h0000, {15'h0, eventPinN});
        end
        frame(16'hE000, 99);
        check("buffer read first", {4'h2, 8'(32'h11 + takenCnt - 2), 4'h0}, shown);
        frame(16'hE000, 99);
        check("buffer read second", {4'h2, 8'(32'h11 + takenCnt - 1), 4'h0}, shown);
        check("interrupt after drain", 16'h0001, {15'h0, eventPinN});
        frame(16'hA300, 99);
        frame(16'h8000, 99);
        check("power down", 16'h0001, {15'h0, powerDown});
        frame(16'h9000, 99);
        check("setup kept in power down", 16'h0300, {4'h0, setupSeen});
        t = takenCnt + 1;
        frame(16'h1000, 99);
        clocks(11);
        check("long sampling", 16'h0001, {15'h0, sampleHold});
        clocks(1);
        tick(2);
        tickBase = tickCnt;
        clocks(3);
        tick(2);
        check("divided conversion clock", 16'h0001, 16'(tickCnt - tickBase));
        check("power up", 16'h0000, {15'h0, powerDown});
        waitTaken(t);
        dsp = 1'b1;
        csN <= 1'b0;
        tick(8);
        t = takenCnt + 1;
        frame(16'h2000, 99);
        check("frame sync result", {4'h1, 8'(32'h10 + takenCnt), 4'h0}, shown);
        clocks(12);
        waitTaken(t);
        frame(16'hE000, 99);
        check("frame sync channel", {4'h2, 8'(32'h10 + takenCnt), 4'h0}, shown);
        results();
    end
endmodule
`default_nettype wire
